// File: common/sfg_pkg.sv
// Package of offsets, field positions and reset values for the flag and command block
package sfg_pkg;
	// ==========================================
	// Register byte addresses
	localparam logic [6:0] FLAGS_LO_ADDR = 7'h3c;
	localparam logic [6:0] FLAGS_HI_ADDR = 7'h3d;
	localparam logic [6:0] TRIG_LO_ADDR = 7'h3e;
	localparam logic [6:0] TRIG_HI_ADDR = 7'h3f;
	// ==========================================
	// Reset values
	localparam logic [15:0] FLAGS_RESET = 16'h0000;
	localparam logic [15:0] TRIG_RESET = 16'h0000;
	localparam logic [15:0] TRIM_RESET = 16'h0000;
	// ==========================================
	// Flag bit positions
	localparam int FLG_SUPPLY_LOW = 0;
	localparam int FLG_SUPPLY_HIGH = 1;
	localparam int FLG_CTRL_UPD = 2;
	localparam int FLG_SERIAL = 3;
	localparam int FLG_SELF_TEST = 5;
	localparam int FLG_ALARM1 = 8;
	localparam int FLG_ALARM2 = 9;
	localparam logic [15:0] FLAGS_USED_MASK = 16'h032f;
	// Alarm indication bit in output data words
	localparam int DATA_ALARM_BIT = 14;
	// ==========================================
	// Command bit positions
	localparam int CMD_NULL = 0;
	localparam int CMD_FACTORY = 1;
	localparam int CMD_DAC_LATCH = 2;
	localparam int CMD_FLASH = 3;
	localparam int CMD_CLEAR = 4;
	localparam int CMD_SOFT_RST = 7;
	// ==========================================
	// Flash commit busy time
	localparam int FLASH_TIME_MS = 50;
	localparam int CLK_MHZ = 125;
	localparam int FLASH_CYCLES = FLASH_TIME_MS * 1000 * CLK_MHZ;
endpackage

// File: rtl/sfg_pulse_edge.sv
// Rising-edge detector turning a level into a one-cycle pulse
`timescale 1ns/1ps
module sfg_pulse_edge (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Level in, pulse out
	input wire logic levelIn,
	output logic pulseOut
);
	logic prev_ff;
	logic nxt_prev;

	always_comb begin
		nxt_prev = levelIn;
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			prev_ff <= 1'b0;
		end else begin
			prev_ff <= nxt_prev;
		end
	end

	assign pulseOut = levelIn & ~prev_ff;
endmodule

// File: rtl/sfg_flags_cmd.sv
// Fault flag register and global command register of the tilt sensor
`timescale 1ns/1ps
module sfg_flags_cmd #(
	parameter int FLASH_CYCLES = sfg_pkg::FLASH_CYCLES
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Byte register port
	input wire logic regWrEn,
	input wire logic [6:0] regAddr,
	input wire logic [7:0] regWrData,
	output logic [7:0] regRdData,
	// Condition inputs, one cycle evaluation each
	input wire logic condAlarm1,
	input wire logic condAlarm2,
	input wire logic condSelfTest,
	input wire logic condSerial,
	input wire logic condCtrlUpd,
	input wire logic supplyHigh,
	input wire logic supplyLow,
	// Auxiliary converter
	input wire logic [15:0] dacLevel,
	output logic [15:0] dacOut,
	// Inclination trim
	input wire logic [15:0] tiltAngle,
	output logic [15:0] tilt_offset_trim,
	// Command hooks
	output logic filterFlush,
	output logic softReset,
	output logic flashBusy,
	output logic alarmIndicator
);
	logic [15:0] flags_ff, nxt_flags;
	logic [15:0] dac_ff, nxt_dac;
	logic [15:0] trim_ff, nxt_trim;
	logic [7:0] cmdLo;
	logic [7:0] rdData_ff, nxt_rdData;
	logic [31:0] flashCnt_ff, nxt_flashCnt;
	logic flush_ff, nxt_flush;
	logic soft_ff, nxt_soft;
	logic clrLevel, clrPulse, lowWr;
	logic [15:0] setVec;

	// ==========================================
	// Command decode
	assign lowWr = regWrEn && (regAddr == sfg_pkg::TRIG_LO_ADDR);
	assign cmdLo = lowWr ? regWrData : sfg_pkg::TRIG_RESET[7:0];
	assign clrLevel = cmdLo[sfg_pkg::CMD_CLEAR];

	// edge makes one clear per write
	sfg_pulse_edge uClr (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.levelIn(clrLevel),
		.pulseOut(clrPulse)
	);

	// ==========================================
	// Flag register
	always_comb begin
		setVec = '0;
		setVec[sfg_pkg::FLG_ALARM1] = condAlarm1;
		setVec[sfg_pkg::FLG_ALARM2] = condAlarm2;
		setVec[sfg_pkg::FLG_SELF_TEST] = condSelfTest;
		setVec[sfg_pkg::FLG_SERIAL] = condSerial;
		setVec[sfg_pkg::FLG_CTRL_UPD] = condCtrlUpd;
		setVec[sfg_pkg::FLG_SUPPLY_HIGH] = supplyHigh;
		setVec[sfg_pkg::FLG_SUPPLY_LOW] = supplyLow;
		nxt_flags = flags_ff;
		// clear all, soft reset also clears
		if (clrPulse || soft_ff) begin
			nxt_flags = sfg_pkg::FLAGS_RESET;
		end
		nxt_flags[sfg_pkg::FLG_SUPPLY_HIGH] = 1'b0;
		nxt_flags[sfg_pkg::FLG_SUPPLY_LOW] = 1'b0;
		// set each cycle, wins over clear
		nxt_flags = (nxt_flags | setVec) & sfg_pkg::FLAGS_USED_MASK;
	end

	// ==========================================
	// Command actions
	always_comb begin
		nxt_dac = dac_ff;
		nxt_trim = trim_ff;
		nxt_flashCnt = flashCnt_ff;
		nxt_flush = 1'b0;
		nxt_soft = 1'b0;
		nxt_rdData = sfg_pkg::TRIG_RESET[7:0];
		if (cmdLo[sfg_pkg::CMD_DAC_LATCH]) begin
			nxt_dac = dacLevel;
		end
		// factory reset of trim and filters
		if (cmdLo[sfg_pkg::CMD_FACTORY]) begin
			nxt_trim = sfg_pkg::TRIM_RESET;
			nxt_flush = 1'b1;
		end else if (cmdLo[sfg_pkg::CMD_NULL]) begin
			nxt_trim = 16'(trim_ff - tiltAngle);
		end
		if (flashCnt_ff != 32'h0000_0000) begin
			nxt_flashCnt = flashCnt_ff - 32'h0000_0001;
		end
		if (cmdLo[sfg_pkg::CMD_FLASH] || cmdLo[sfg_pkg::CMD_FACTORY] ||
			cmdLo[sfg_pkg::CMD_NULL]) begin
			nxt_flashCnt = 32'(FLASH_CYCLES);
		end
		nxt_soft = cmdLo[sfg_pkg::CMD_SOFT_RST];
		case (regAddr)
			sfg_pkg::FLAGS_LO_ADDR: nxt_rdData = flags_ff[7:0];
			sfg_pkg::FLAGS_HI_ADDR: nxt_rdData = flags_ff[15:8];
			default: nxt_rdData = 8'h00;
		endcase
	end

	// defaults via reset until first write
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			flags_ff <= sfg_pkg::FLAGS_RESET;
			dac_ff <= 16'h0000;
			trim_ff <= sfg_pkg::TRIM_RESET;
			flashCnt_ff <= 32'h0000_0000;
			flush_ff <= 1'b0;
			soft_ff <= 1'b0;
			rdData_ff <= 8'h00;
		end else begin
			flags_ff <= nxt_flags;
			dac_ff <= nxt_dac;
			trim_ff <= nxt_trim;
			flashCnt_ff <= nxt_flashCnt;
			flush_ff <= nxt_flush;
			soft_ff <= nxt_soft;
			rdData_ff <= nxt_rdData;
		end
	end

	assign regRdData = rdData_ff;
	assign dacOut = dac_ff;
	assign tilt_offset_trim = trim_ff;
	assign filterFlush = flush_ff;
	assign softReset = soft_ff;
	assign flashBusy = (flashCnt_ff != 32'h0000_0000);
	assign alarmIndicator = |flags_ff;

	// ==========================================
	// Checks
	AST_FLAG_SET: assert property (@(posedge clk_sys) disable iff (sys_rst)
		condAlarm1 |=> flags_ff[sfg_pkg::FLG_ALARM1]) else $error("alarm1 flag not set");
	AST_SET_WINS: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clrPulse |=> (flags_ff & $past(setVec)) == $past(setVec)) else $error("set lost");
	AST_CLEAR: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(clrPulse && setVec == 16'h0000) |=> flags_ff == 16'h0000) else $error("clear failed");
	AST_ONCE: assert property (@(posedge clk_sys) disable iff (sys_rst)
		clrPulse |=> !clrPulse) else $error("clear repeated");
	AST_SUPPLY: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!supplyHigh |=> !flags_ff[sfg_pkg::FLG_SUPPLY_HIGH]) else $error("supply flag stuck");
	AST_ALARM_BIT: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(setVec != 16'h0000) |=> alarmIndicator) else $error("alarm bit wrong");
	AST_LATCH: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!cmdLo[sfg_pkg::CMD_DAC_LATCH] |=> $stable(dacOut)) else $error("dac moved");
	AST_FACTORY: assert property (@(posedge clk_sys) disable iff (sys_rst)
		cmdLo[sfg_pkg::CMD_FACTORY] |=> (trim_ff == 16'h0000) && filterFlush && flashBusy)
		else $error("factory reset");
	AST_UNUSED: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(flags_ff & ~sfg_pkg::FLAGS_USED_MASK) == 16'h0000) else $error("unused bit set");
	COV_CLEAR: cover property (@(posedge clk_sys) clrPulse && flags_ff != 16'h0000);
	COV_LATCH: cover property (@(posedge clk_sys) cmdLo[sfg_pkg::CMD_DAC_LATCH]);
	COV_NULL: cover property (@(posedge clk_sys) cmdLo[sfg_pkg::CMD_NULL]);
endmodule

// File: verif/sfg_host_model.sv
// Host model driving the byte register port
`timescale 1ns/1ps
module sfg_host_model (
	// Clock
	input wire logic clk_sys,
	// Byte register port
	output logic regWrEn,
	output logic [6:0] regAddr,
	output logic [7:0] regWrData,
	input wire logic [7:0] regRdData,
	// Flash commit status
	input wire logic flashBusy
);
	logic [7:0] rdByte;
	event rdEv;
	initial begin
		regWrEn = 1'b0;
		regAddr = 7'h00;
		regWrData = 8'h00;
	end
	// ==========================================
	// Transfers, launched on the falling edge
	// Strobe may stand several cycles to probe the one-shot clear
	task automatic wr(input logic [6:0] a, input logic [7:0] d, input int len = 1);
		int n;
		n = 0;
		while (flashBusy === 1'b1 && n < 100) begin
			@(negedge clk_sys);
			n++;
		end
		@(negedge clk_sys);
		regWrEn = 1'b1;
		regAddr = a;
		regWrData = d;
		repeat (len) @(negedge clk_sys);
		regWrEn = 1'b0;
		regWrData = ~d;
	endtask
	task automatic rd(input logic [6:0] a);
		@(negedge clk_sys);
		regAddr = a;
		@(negedge clk_sys);
		rdByte = regRdData;
		->rdEv;
	endtask
endmodule

// File: verif/tb_top.sv
// Self-checking bench for the flag and command block
`timescale 1ns/1ps
module tb_top;
	localparam logic [6:0] CMD = sfg_pkg::TRIG_LO_ADDR;
	localparam int BUSY_CYCLES = 20;
	logic clk_sys, sys_rst, regWrEn, filterFlush, softReset, flashBusy, alarmIndicator;
	logic condAlarm1, condAlarm2, condSelfTest, condSerial, condCtrlUpd, supplyHigh, supplyLow;
	logic [6:0] cond, regAddr, c;
	logic [7:0] regWrData, regRdData;
	logic [7:0] expQ[$];
	logic [15:0] dacLevel, tiltAngle, dacOut, trim;
	int errorCnt = 0;
	int nCompared = 0;
	assign {condAlarm2, condAlarm1, condSelfTest, condSerial, condCtrlUpd, supplyHigh, supplyLow} = cond;
	sfg_flags_cmd #(.FLASH_CYCLES(BUSY_CYCLES)) uut (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.regWrEn(regWrEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
		.condAlarm1(condAlarm1), .condAlarm2(condAlarm2), .condSelfTest(condSelfTest),
		.condSerial(condSerial), .condCtrlUpd(condCtrlUpd), .supplyHigh(supplyHigh),
		.supplyLow(supplyLow), .dacLevel(dacLevel), .dacOut(dacOut), .tiltAngle(tiltAngle),
		.tilt_offset_trim(trim), .filterFlush(filterFlush), .softReset(softReset),
		.flashBusy(flashBusy), .alarmIndicator(alarmIndicator));
	sfg_host_model host (.clk_sys(clk_sys), .regWrEn(regWrEn), .regAddr(regAddr),
		.regWrData(regWrData), .regRdData(regRdData), .flashBusy(flashBusy));
	// ==========================================
	// Checking
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		nCompared++;
		if (seen !== exp) begin
			errorCnt++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finishTest();
		if (errorCnt == 0 && nCompared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	always @(host.rdEv) begin
		chk(host.rdByte, expQ.pop_front());
	end
	task automatic rdFlags(input logic [15:0] e);
		expQ.push_back(e[7:0]);
		host.rd(sfg_pkg::FLAGS_LO_ADDR);
		expQ.push_back(e[15:8]);
		host.rd(sfg_pkg::FLAGS_HI_ADDR);
	endtask
	task automatic setCond(input logic [6:0] v);
		@(negedge clk_sys);
		cond = v;
	endtask
	// ==========================================
	// Stimulus
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	initial begin
		#100000;
		errorCnt++;
		finishTest();
	end
	initial begin
		void'($urandom(80));
		sys_rst = 1'b1;
		cond = 7'h00;
		dacLevel = 16'h0000;
		tiltAngle = 16'h0000;
		repeat (10) @(negedge clk_sys);
		sys_rst = 1'b0;
		rdFlags(16'h0000);
		expQ.push_back(8'h00);
		host.rd(CMD);
		c = 7'($urandom) | 7'h04;
		setCond(c);
		setCond(7'h00);
		rdFlags({6'h00, c[6:5], 2'b00, c[4], 1'b0, c[3:2], 2'b00});
		chk(alarmIndicator, 16'h0001);
		host.wr(sfg_pkg::FLAGS_LO_ADDR, 8'hff);
		rdFlags({6'h00, c[6:5], 2'b00, c[4], 1'b0, c[3:2], 2'b00});
		host.wr(CMD, 8'h10);
		setCond(7'h03);
		rdFlags(16'h0003);
		setCond(7'h00);
		rdFlags(16'h0000);
		setCond(7'h20);
		host.wr(CMD, 8'h10);
		rdFlags(16'h0100);
		setCond(7'h00);
		rdFlags(16'h0100);
		host.wr(CMD, 8'h10);
		chk(alarmIndicator, 16'h0000);
		// strobe held two cycles, alarm only in the first
		fork
			host.wr(CMD, 8'h10, 2);
			begin
				setCond(7'h40);
				setCond(7'h00);
			end
		join
		rdFlags(16'h0200);
		dacLevel = 16'($urandom);
		@(negedge clk_sys);
		chk(dacOut, 16'h0000);
		host.wr(CMD, 8'h04);
		chk(dacOut, dacLevel);
		dacLevel = ~dacLevel;
		host.wr(sfg_pkg::TRIG_HI_ADDR, 8'hff);
		chk(dacOut, ~dacLevel);
		tiltAngle = 16'($urandom);
		host.wr(CMD, 8'h01);
		chk(trim, 16'h0000 - tiltAngle);
		chk(flashBusy, 16'h0001);
		host.wr(CMD, 8'h02);
		chk(trim, 16'h0000);
		chk(filterFlush, 16'h0001);
		host.wr(CMD, 8'h08);
		chk(flashBusy, 16'h0001);
		repeat (BUSY_CYCLES - 1) @(negedge clk_sys);
		chk(flashBusy, 16'h0001);
		@(negedge clk_sys);
		chk(flashBusy, 16'h0000);
		setCond(7'h08);
		setCond(7'h00);
		host.wr(CMD, 8'h80);
		chk(softReset, 16'h0001);
		rdFlags(16'h0000);
		finishTest();
	end
endmodule
